// ### hw/slm_map.svh
/*
  Register offsets, bit positions, reset values and sizes of the SYSREF/LMFC
  sync monitor. Assumes the includer only needs plain `define constants.
*/
`ifndef SLM_MAP_SVH
`define SLM_MAP_SVH
`define SLM_A_MASK 12'h020
`define SLM_A_FLAG 12'h024
`define SLM_A_FRM 12'h031
`define SLM_A_CLK0 12'h032
`define SLM_A_CLK1 12'h033
`define SLM_A_MEAS0 12'h034
`define SLM_A_MEAS1 12'h035
`define SLM_A_TALLY 12'h036
`define SLM_A_PH0 12'h037
`define SLM_A_PH1 12'h038
`define SLM_A_TOL 12'h039
`define SLM_A_MODE 12'h03a
`define SLM_A_TX 12'h03f
`define SLM_B_JIT 4
`define SLM_B_RDY 3
`define SLM_B_FIFO 2
`define SLM_B_PQ 1
`define SLM_B_PI 0
`define SLM_B_GATE 7
`define SLM_B_PINSEL 2
`define SLM_EV_W 5
`define SLM_RST_GATE 1'b1
`define SLM_RST_PINSEL 1'b0
`define SLM_DAC_W 16
`define SLM_LMFC_PERIOD 128
`define SLM_FRAME_CLKS 4
`endif

// ### hw/slm_pkg.sv
/*
  Types of the SYSREF/LMFC sync monitor: sync modes and the packed state
  records. Assumes slm_map.svh is on the include path.
*/
`include "slm_map.svh"
package slm_pkg;
   typedef enum logic [1:0] {
      SLM_MON = 2'b00,
      SLM_CONT = 2'b01,
      SLM_ONCE = 2'b10,
      SLM_RSVD = 2'b11
   } slm_mode_t;

   typedef struct packed {
      logic [11:0] cnt;
      logic run;
      logic [11:0] mcnt;
      logic [11:0] meas;
      logic valid;
   } slm_lmfc_t;

   typedef struct packed {
      logic [`SLM_EV_W-1:0] mask;
      logic [`SLM_EV_W-1:0] flag;
      logic [4:0] frames;
      logic [11:0] clocks;
      logic [5:0] tol;
      slm_mode_t mode;
      logic gate;
      logic pinsel;
      logic [7:0] tally;
      logic [7:0] snap_tally;
      logic [11:0] snap_meas;
      logic [11:0] snap_phase;
      logic [11:0] live_meas;
      logic [11:0] live_phase;
      logic have_prev;
      logic sr_meta;
      logic sr_sync;
      logic sr_prev;
      logic tx_meta;
      logic tx_sync;
      logic [11:0] ph_meta;
      logic [11:0] ph_sync;
      logic [7:0] rdata;
      logic rvalid;
      logic [`SLM_DAC_W-1:0] dac;
   } slm_state_t;
endpackage

// ### hw/slm_lmfc.sv
/*
  LMFC down-counter with realign load and SYSREF-to-LMFC delay measurement.
  Assumes i_ref_rise and i_realign are single-cycle pulses on i_clk.
*/
`include "slm_map.svh"
module slm_lmfc #(
   parameter int PERIOD = `SLM_LMFC_PERIOD,
   parameter int FRAME_CLKS = `SLM_FRAME_CLKS
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_ref_rise,
   input wire logic i_realign,
   input wire logic [4:0] i_frames,
   input wire logic [11:0] i_clocks,
   output logic o_lmfc_edge,
   output logic [11:0] o_meas,
   output logic o_meas_valid
);
   slm_pkg::slm_lmfc_t q;
   slm_pkg::slm_lmfc_t d;

   // Total offset folded into one multiframe
   function automatic logic [11:0] delay_mod(input logic [4:0] f, input logic [11:0] c);
      int unsigned t;
      t = int'(f) * FRAME_CLKS + int'(c);
      delay_mod = 12'(t % PERIOD);
   endfunction

   always_comb
   begin
      d = q;
      d.valid = 1'b0;
      if (q.cnt == 12'h000)
         d.cnt = 12'(PERIOD - 1);
      else
         d.cnt = q.cnt - 12'h001;
      if (q.run)
         d.mcnt = q.mcnt + 12'h001;
      if (q.run && q.cnt == 12'h000)
      begin
         d.meas = {q.mcnt[11:2], 2'b00};
         d.valid = 1'b1;
         d.run = 1'b0;
      end
      if (i_ref_rise)
      begin
         d.run = 1'b1;
         d.mcnt = 12'h000;
      end
      if (i_realign)
         d.cnt = delay_mod(i_frames, i_clocks);
      if (i_srst)
         d = '0;
   end

   always_ff @(posedge i_clk)
      q <= d;

   assign o_lmfc_edge = (q.cnt == 12'h000);
   assign o_meas = q.meas;
   assign o_meas_valid = q.valid;
endmodule

// ### hw/slm_top.sv
/*
  SYSREF/LMFC sync monitor: register file, sync modes, event flags, irq and
  DAC data gate. Assumes a simple one-cycle register port, event inputs on
  i_clk, and SYSREF, TX enable pin and phase sampler asynchronous.
*/
`include "slm_map.svh"
module slm_top #(
   parameter int LMFC_PERIOD = `SLM_LMFC_PERIOD,
   parameter int FRAME_CLKS = `SLM_FRAME_CLKS
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [11:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   input wire logic i_sysref,
   input wire logic i_tx_enable_pin,
   input wire logic [11:0] i_ref_event_phase,
   input wire logic i_link_receiver_ready,
   input wire logic i_lane_fifo_err,
   input wire logic i_quad_pattern_err,
   input wire logic i_inphase_pattern_err,
   input wire logic [`SLM_DAC_W-1:0] i_dp_data,
   output logic [`SLM_DAC_W-1:0] o_dac_data,
   output logic o_irq,
   output logic o_lmfc_edge,
   output logic o_realign
);
   slm_pkg::slm_state_t q;
   slm_pkg::slm_state_t d;
   logic ref_rise;
   logic realign;
   logic meas_valid;
   logic [11:0] meas;
   logic jitter;
   logic [11:0] diff;
   logic [11:0] window;
   logic [`SLM_EV_W-1:0] ev;

   assign ref_rise = q.sr_sync & ~q.sr_prev;
   assign realign = ref_rise && (q.mode == slm_pkg::SLM_CONT || q.mode == slm_pkg::SLM_ONCE);

   slm_lmfc #(
      .PERIOD(LMFC_PERIOD),
      .FRAME_CLKS(FRAME_CLKS)
   ) u_lmfc (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_ref_rise(ref_rise),
      .i_realign(realign),
      .i_frames(q.frames),
      .i_clocks(q.clocks),
      .o_lmfc_edge(o_lmfc_edge),
      .o_meas(meas),
      .o_meas_valid(meas_valid)
   );

   assign diff = (meas > q.live_meas) ? meas - q.live_meas : q.live_meas - meas;
   assign window = {6'h00, q.tol[5:2], 2'b00};
   assign jitter = meas_valid && q.have_prev && (diff > window);
   assign ev[`SLM_B_JIT] = jitter;
   assign ev[`SLM_B_RDY] = ~i_link_receiver_ready;
   assign ev[`SLM_B_FIFO] = i_lane_fifo_err;
   assign ev[`SLM_B_PQ] = i_quad_pattern_err;
   assign ev[`SLM_B_PI] = i_inphase_pattern_err;

   always_comb
   begin
      d = q;
      // Metastability guard, first stage read only by second
      d.sr_meta = i_sysref;
      d.sr_sync = q.sr_meta;
      d.sr_prev = q.sr_sync;
      d.tx_meta = i_tx_enable_pin;
      d.tx_sync = q.tx_meta;
      d.ph_meta = i_ref_event_phase;
      d.ph_sync = q.ph_meta;
      if (ref_rise)
      begin
         d.tally = q.tally + 8'h01;
         d.live_phase = q.ph_sync;
      end
      if (realign && q.mode == slm_pkg::SLM_ONCE)
         d.mode = slm_pkg::SLM_MON;
      if (meas_valid)
      begin
         d.live_meas = meas;
         d.have_prev = 1'b1;
      end
      if (i_reg_wr)
      begin
         case (i_reg_addr)
            `SLM_A_MASK: d.mask = i_reg_wdata[`SLM_EV_W-1:0];
            `SLM_A_FLAG: d.flag = q.flag & ~i_reg_wdata[`SLM_EV_W-1:0];
            `SLM_A_FRM: d.frames = i_reg_wdata[4:0];
            `SLM_A_CLK0: d.clocks[7:0] = i_reg_wdata;
            `SLM_A_CLK1: d.clocks[11:8] = i_reg_wdata[3:0];
            `SLM_A_MEAS0, `SLM_A_MEAS1, `SLM_A_PH0, `SLM_A_PH1:
            begin
               d.snap_meas = q.live_meas;
               d.snap_phase = q.live_phase;
               d.snap_tally = q.tally;
            end
            `SLM_A_TALLY:
            begin
               d.tally = 8'h00;
               d.snap_tally = 8'h00;
            end
            `SLM_A_TOL: d.tol = i_reg_wdata[5:0];
            `SLM_A_MODE: d.mode = slm_pkg::slm_mode_t'(i_reg_wdata[1:0]);
            `SLM_A_TX:
            begin
               d.gate = i_reg_wdata[`SLM_B_GATE];
               d.pinsel = i_reg_wdata[`SLM_B_PINSEL];
            end
            default:
            begin
            end
         endcase
      end
      // inphase error sets
      // Set beats a same-cycle clear so no event is lost
      d.flag = d.flag | ev;
      d.rvalid = i_reg_rd;
      d.rdata = 8'h00;
      if (i_reg_rd)
      begin
         case (i_reg_addr)
            `SLM_A_MASK: d.rdata = {3'h0, q.mask};
            `SLM_A_FLAG: d.rdata = {3'h0, q.flag};
            `SLM_A_FRM: d.rdata = {3'h0, q.frames};
            `SLM_A_CLK0: d.rdata = q.clocks[7:0];
            `SLM_A_CLK1: d.rdata = {4'h0, q.clocks[11:8]};
            `SLM_A_MEAS0: d.rdata = q.snap_meas[7:0];
            `SLM_A_MEAS1: d.rdata = {4'h0, q.snap_meas[11:8]};
            `SLM_A_TALLY: d.rdata = q.snap_tally;
            `SLM_A_PH0: d.rdata = q.snap_phase[7:0];
            `SLM_A_PH1: d.rdata = {4'h0, q.snap_phase[11:8]};
            `SLM_A_TOL: d.rdata = {2'h0, q.tol};
            `SLM_A_MODE: d.rdata = {6'h00, q.mode};
            `SLM_A_TX: d.rdata = {q.gate, 4'h0, q.pinsel, 2'h0};
            default: d.rdata = 8'h00;
         endcase
      end
      if (q.pinsel ? q.tx_sync : q.gate)
         d.dac = i_dp_data;
      else
         d.dac = '0;
      if (i_srst)
      begin
         d = '0;
         d.gate = `SLM_RST_GATE;
         d.pinsel = `SLM_RST_PINSEL;
      end
   end

   always_ff @(posedge i_clk)
      q <= d;

   assign o_reg_rdata = q.rdata;
   assign o_reg_rvalid = q.rvalid;
   assign o_dac_data = q.dac;
   assign o_realign = realign;
   assign o_irq = |(q.flag & q.mask);

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   // Pin edge reaches the detector one cycle after the first stage
   sequence s_pin_rise(slm_pkg::slm_mode_t m);
      (q.mode == m && q.sr_meta && !q.sr_sync && !i_reg_wr) ##1 (q.mode == m);
   endsequence

   sequence s_flag_wr(int b);
      i_reg_wr && i_reg_addr == `SLM_A_FLAG && i_reg_wdata[b];
   endsequence

   sequence s_flag_clear(int b);
      s_flag_wr(b) ##0 !ev[b];
   endsequence

   property p_jit_hold;
      q.flag[`SLM_B_JIT] && !(i_reg_wr && i_reg_addr == `SLM_A_FLAG) |=> q.flag[`SLM_B_JIT];
   endproperty
   a_jit_hold: assert property (p_jit_hold) else $error("jitter flag dropped");

   property p_rdy;
      !i_link_receiver_ready |=> q.flag[`SLM_B_RDY] ##1 (q.flag[`SLM_B_RDY] || $past(i_reg_wr));
   endproperty
   a_rdy: assert property (p_rdy) else $error("ready-low flag not held");

   property p_fifo;
      i_lane_fifo_err |=> q.flag[`SLM_B_FIFO];
   endproperty
   a_fifo: assert property (p_fifo) else $error("fifo flag missed");

   property p_quad;
      s_flag_clear(`SLM_B_PQ) |=> !q.flag[`SLM_B_PQ];
   endproperty
   a_quad: assert property (p_quad) else $error("quad flag not cleared");

   property p_inph;
      i_inphase_pattern_err ##0 s_flag_wr(`SLM_B_PI) |=> q.flag[`SLM_B_PI];
   endproperty
   a_inph: assert property (p_inph) else $error("inphase flag lost");

   property p_irq;
      q.flag[`SLM_B_PI] && !q.mask[`SLM_B_PI] && !(|(q.flag[4:1] & q.mask[4:1])) |-> !o_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq with no enabled flag");

   property p_snap;
      i_reg_wr && (i_reg_addr == `SLM_A_MEAS0 || i_reg_addr == `SLM_A_PH1) |=>
         q.snap_meas == $past(q.live_meas) && q.snap_meas[1:0] == 2'b00;
   endproperty
   a_snap: assert property (p_snap) else $error("snapshot mismatch");

   property p_tally;
      i_reg_wr && i_reg_addr == `SLM_A_TALLY |=> q.tally == 8'h00 ##1 q.tally <= 8'h01;
   endproperty
   a_tally: assert property (p_tally) else $error("tally not reset");

   property p_mon;
      s_pin_rise(slm_pkg::SLM_MON) |-> !realign;
   endproperty
   a_mon: assert property (p_mon) else $error("realign in monitor mode");

   property p_cont;
      s_pin_rise(slm_pkg::SLM_CONT) |-> realign ##1 q.mode == slm_pkg::SLM_CONT;
   endproperty
   a_cont: assert property (p_cont) else $error("continuous realign missed");

   property p_once;
      s_pin_rise(slm_pkg::SLM_ONCE) ##0 !i_reg_wr |-> realign ##1 q.mode == slm_pkg::SLM_MON;
   endproperty
   a_once: assert property (p_once) else $error("one-shot did not fall back");

   property p_gate;
      !q.pinsel && !q.gate |=> o_dac_data == '0;
   endproperty
   a_gate: assert property (p_gate) else $error("data passed while gated");

   property p_pin;
      q.pinsel && q.tx_sync |=> o_dac_data == $past(i_dp_data);
   endproperty
   a_pin: assert property (p_pin) else $error("pin gate ignored");

   property p_mask;
      i_reg_wr && i_reg_addr == `SLM_A_MASK |=> q.mask == 5'($past(i_reg_wdata));
   endproperty
   a_mask: assert property (p_mask) else $error("enable write lost");

   property p_frm;
      i_reg_wr && i_reg_addr == `SLM_A_FRM |=> q.frames == 5'($past(i_reg_wdata));
   endproperty
   a_frm: assert property (p_frm) else $error("frame offset write lost");

   property p_meas_lsb;
      meas_valid |-> meas[1:0] == 2'b00;
   endproperty
   a_meas_lsb: assert property (p_meas_lsb) else $error("measured offset low bits set");

   property p_tol;
      i_reg_wr && i_reg_addr == `SLM_A_TOL |=> q.tol == 6'($past(i_reg_wdata));
   endproperty
   a_tol: assert property (p_tol) else $error("tolerance write lost");
endmodule

// ### tb/slm_ref_src.sv
/*
  Far-side model: SYSREF source, phase sampler and link receiver ready.
  Assumes the bench pulses i_fire for one cycle, at least four cycles apart.
*/
module slm_ref_src (
   input wire logic i_clk,
   input wire logic i_fire,
   input wire logic i_drop,
   output logic o_sysref,
   output logic [11:0] o_phase,
   output logic o_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] hold_q = 2'h0;
   // Two cycles high so the two-flop synchroniser cannot miss it
   always @(posedge i_clk)
   begin
      if (i_fire)
         hold_q <= 2'h2;
      else if (hold_q != 2'h0)
         hold_q <= hold_q - 2'h1;
   end
   assign o_sysref = (hold_q != 2'h0);
   assign o_phase = 12'h00f;
   assign o_ready = !i_drop;
endmodule

// ### tb/sysref_lmfc_sync_monitor_tb.sv
/*
  Self-checking bench of slm_top: registers, flags, sync modes, data gate.
  Assumes slm_map.svh on the include path and the slm_ref_src model.
*/
module sysref_lmfc_sync_monitor_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic rvalid;
   logic sysref;
   logic txpin = 1'b0;
   logic [11:0] phase;
   logic ready;
   logic [2:0] ev = 3'h0;
   logic [15:0] dp = 16'h0000;
   logic [15:0] dac;
   logic irq;
   logic lmfc;
   logic realign;
   logic fire = 1'b0;
   logic drop = 1'b0;
   int bad_count = 0;
   int tests_run = 0;
   int realigns = 0;

   slm_top #(.LMFC_PERIOD(128), .FRAME_CLKS(4)) dut_u (.i_clk(clk), .i_srst(srst), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_sysref(sysref), .i_tx_enable_pin(txpin), .i_ref_event_phase(phase), .i_link_receiver_ready(ready),
      .i_lane_fifo_err(ev[2]), .i_quad_pattern_err(ev[1]), .i_inphase_pattern_err(ev[0]),
      .i_dp_data(dp), .o_dac_data(dac), .o_irq(irq), .o_lmfc_edge(lmfc), .o_realign(realign));
   slm_ref_src ref_u (.i_clk(clk), .i_fire(fire), .i_drop(drop), .o_sysref(sysref), .o_phase(phase),
      .o_ready(ready));

   initial
   begin
      forever #20 clk = !clk;
   end
   always @(posedge clk)
   begin
      if (realign === 1'b1)
         realigns++;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      int n;
      n = 0;
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      while (rvalid !== 1'b1 && n < 3)
      begin
         @(negedge clk);
         n++;
      end
      chk({8'h00, rdata}, {8'h00, e});
   endtask
   // Fires one pulse and returns cycles from realign to the LMFC edge
   task automatic sync_pulse(output int n);
      int k;
      n = 0;
      k = 0;
      @(negedge clk);
      fire = 1'b1;
      @(negedge clk);
      fire = 1'b0;
      while (realign !== 1'b1 && k < 10)
      begin
         @(negedge clk);
         k++;
      end
      // Old counter may sit at zero in the realign cycle itself
      @(negedge clk);
      n = 1;
      while (lmfc !== 1'b1 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic t_regs;
      logic [11:0] ta [5] = '{12'h031, 12'h032, 12'h033, 12'h039, 12'h03a};
      logic [7:0] te [5] = '{8'h1f, 8'hff, 8'h0f, 8'h3f, 8'h03};
      rd_chk(12'h03f, 8'h80);
      rd_chk(12'h024, 8'h00);
      rd_chk(12'h020, 8'h00);
      rd_chk(12'h030, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         wr_reg(ta[i], 8'hff);
         rd_chk(ta[i], te[i]);
         wr_reg(ta[i], 8'h00);
      end
      $display("test regs done");
   endtask

   task automatic t_flags;
      for (int k = 0; k < 4; k++)
      begin
         @(negedge clk);
         if (k < 3)
            ev[k] = 1'b1;
         else
            drop = 1'b1;
         @(negedge clk);
         ev = 3'h0;
         drop = 1'b0;
         rd_chk(12'h024, 8'h01 << k);
         chk({15'h0, irq}, 16'h0000);
         wr_reg(12'h020, 8'h01 << k);
         chk({15'h0, irq}, 16'h0001);
         wr_reg(12'h024, 8'h01 << k);
         @(negedge clk);
         chk({15'h0, irq}, 16'h0000);
         rd_chk(12'h024, 8'h00);
      end
      // Set and clear in one cycle, set wins
      @(negedge clk);
      wr = 1'b1;
      addr = 12'h024;
      wdata = 8'h01;
      ev[0] = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      ev = 3'h0;
      rd_chk(12'h024, 8'h01);
      wr_reg(12'h024, 8'h01);
      rd_chk(12'h024, 8'h00);
      wr_reg(12'h020, 8'h1f);
      $display("test flags done");
   endtask

   task automatic t_sync;
      int n;
      wr_reg(12'h031, 8'h01);
      wr_reg(12'h032, 8'h01);
      wr_reg(12'h03a, 8'h01);
      sync_pulse(n);
      chk(n[15:0], 16'd6);
      // Measurement lands two cycles after the edge
      repeat (2) @(negedge clk);
      wr_reg(12'h034, 8'h00);
      rd_chk(12'h034, 8'h04);
      rd_chk(12'h035, 8'h00);
      rd_chk(12'h037, 8'h0f);
      rd_chk(12'h038, 8'h00);
      rd_chk(12'h036, 8'h01);
      wr_reg(12'h036, 8'h00);
      rd_chk(12'h036, 8'h00);
      wr_reg(12'h03a, 8'h02);
      sync_pulse(n);
      chk(n[15:0], 16'd6);
      rd_chk(12'h03a, 8'h00);
      wr_reg(12'h024, 8'h1f);
      realigns = 0;
      // Second pulse fires 61 cycles after the first one's LMFC edge, so the two cannot measure alike
      sync_pulse(n);
      repeat (60) @(negedge clk);
      sync_pulse(n);
      chk(realigns[15:0], 16'h0000);
      repeat (2) @(negedge clk);
      rd_chk(12'h024, 8'h10);
      chk({15'h0, irq}, 16'h0001);
      wr_reg(12'h024, 8'h10);
      rd_chk(12'h024, 8'h00);
      $display("test sync done");
   endtask

   task automatic t_gate;
      dp = 16'h1234;
      repeat (2) @(negedge clk);
      chk(dac, 16'h1234);
      wr_reg(12'h03f, 8'h00);
      repeat (2) @(negedge clk);
      chk(dac, 16'h0000);
      txpin = 1'b1;
      wr_reg(12'h03f, 8'h04);
      repeat (4) @(negedge clk);
      chk(dac, 16'h1234);
      txpin = 1'b0;
      repeat (4) @(negedge clk);
      chk(dac, 16'h0000);
      $display("test gate done");
   endtask

   task automatic end_sim;
      $display("compares %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_sim();
   end
   initial
   begin
      repeat (12) @(negedge clk);
      srst = 1'b0;
      t_regs();
      t_flags();
      t_sync();
      t_gate();
      end_sim();
   end
endmodule
